// *** rtl/ebpc_pkg.sv ***
// Purpose: Shared constants for the external bus pin configuration block.
// Assumes: APB slave, 32-bit data, one register word.
// Notes:   Offsets are byte addresses.
package ebpc_pkg;
  localparam logic [7:0]  CTRL_OFFSET   = 8'h00;
  localparam logic [31:0] CTRL_RESET    = 32'h00000000;
  localparam logic [31:0] CTRL_MASK     = 32'h0000013A;
  localparam int          SEL1_BIT      = 1;
  localparam int          SEL3_BIT      = 3;
  localparam int          SEL4_BIT      = 4;
  localparam int          SEL5_BIT      = 5;
  localparam int          PULLUP_BIT    = 8;
  localparam int          NUM_SEL       = 6;
  localparam int          LOW_DATA_W    = 16;
  localparam int          HIGH_DATA_W   = 16;
  localparam int          FIX_ADDR_W    = 23;
  localparam int          ADDR_W        = 26;
  localparam int          PORTE_W       = 26;
  localparam int          PORTE_ADDR_LO = 16;
  localparam int          PORTE_CE1     = 19;
  localparam int          PORTE_CE2     = 20;
  localparam int          PORTE_SEL4    = 21;
  localparam int          PORTE_SEL5    = 22;
  localparam int          PORTE_RNW     = 23;
  localparam int          PORTE_WAIT    = 24;
  localparam int          PORTE_SEL2    = 25;
  localparam int          FIXED_W       = 54;
endpackage : ebpc_pkg

// *** rtl/ebpc_sync.sv ***
// Purpose: Two flip-flop synchroniser for pin-side inputs.
// Assumes: Asynchronous active-low reset.
// Notes:   Stage one feeds only stage two.
`timescale 1ns/10ps
module ebpc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } ebpc_sync_s;

  ebpc_sync_s st_reg;
  ebpc_sync_s st_next;

  always_comb
  begin
    st_next    = st_reg;
    st_next.s1 = d;
    st_next.s2 = st_reg.s1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign q = st_reg.s2;
endmodule : ebpc_sync

// *** rtl/ebpc_top.sv ***
// Purpose: External bus chip select routing and pin assignment control.
// Assumes: APB master; 25 MHz pclk; controllers run on pclk.
// Notes:   Pin outputs are registered, so they lag the controllers by one.
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/10ps
module ebpc_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Static controller side.
  input  wire logic [5:0]  smc_sel_n,
  input  wire logic [31:0] smc_data_out,
  input  wire logic [31:0] smc_data_oe,
  input  wire logic [25:0] smc_addr,
  input  wire logic        smc_read_strobe_n,
  input  wire logic [3:0]  smc_write_strobe_n,
  input  wire logic        smc_wide_bus,
  // DRAM controller side.
  input  wire logic        dram_sel_n,
  input  wire logic        dram_clock,
  input  wire logic        dram_clock_enable,
  input  wire logic        dram_ras_n,
  input  wire logic        dram_cas_n,
  input  wire logic        dram_write_enable,
  input  wire logic        dram_addr_bit10,
  // Glue requests from the static controller.
  input  wire logic        nand_read_req,
  input  wire logic        nand_write_req,
  input  wire logic        card_enable1_req,
  input  wire logic        card_enable2_req,
  input  wire logic        card_rnw_req,
  // Port E pull-up setting from the port controller.
  input  wire logic [25:0] porte_pullup_cfg,
  // Pins.
  input  wire logic [31:0] data_in,
  input  wire logic        wait_request_n,
  output logic      [31:0] data_out,
  output logic      [31:0] data_oe,
  output logic      [53:0] fixed_pin_out,
  output logic      [25:0] porte_out,
  output logic      [15:0] low_data_pullup_en,
  output logic      [25:0] porte_pullup_en,
  output logic      [31:0] bus_data_in,
  output logic             bus_wait_n,
  output logic             dram_sel_n_out,
  output logic             nand_active,
  output logic             card_active
);
  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] rdata;
    logic        ready;
    logic [31:0] dout;
    logic [31:0] doe;
    logic [53:0] fixed;
    logic [25:0] porte;
    logic [15:0] pull_lo;
    logic [25:0] pull_e;
    logic        dram_sel;
    logic        nand_on;
    logic        card_on;
  } ebpc_top_s;

  ebpc_top_s st_reg;
  ebpc_top_s st_next;

  logic [31:0] data_sync;
  logic [0:0]  wait_sync;
  logic        acc;
  logic        hit;

  // Pin inputs cross from the pad domain before anyone reads them.
  ebpc_sync #(.W(32)) u_data_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (data_in),
    .q       (data_sync)
  );

  ebpc_sync #(.W(1)) u_wait_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (wait_request_n),
    .q       (wait_sync)
  );

  assign acc = psel && penable && !st_reg.ready;
  assign hit = paddr == ebpc_pkg::CTRL_OFFSET;

  always_comb
  begin
    st_next       = st_reg;
    st_next.ready = 1'b0;
    if (acc)
    begin
      // One wait state: the answer comes one cycle into the access phase.
      st_next.ready = 1'b1;
      st_next.rdata = 32'h00000000;
      if (hit && !pwrite)
        st_next.rdata = st_reg.ctrl;
    end
    // A write lands only on the edge at which the master sees pready high.
    if (psel && penable && pwrite && st_reg.ready && hit)
      st_next.ctrl = pwdata & ebpc_pkg::CTRL_MASK;

    // Selects 0, 2 and 3..5 stay with the static controller.
    st_next.dram_sel = st_reg.ctrl[ebpc_pkg::SEL1_BIT] ? dram_sel_n
                                                       : 1'b1;
    st_next.nand_on  = st_reg.ctrl[ebpc_pkg::SEL3_BIT];
    st_next.card_on  = st_reg.ctrl[ebpc_pkg::SEL4_BIT]
                     | st_reg.ctrl[ebpc_pkg::SEL5_BIT];

    // The fixed pins: data 0-15, address 0-22, then selects 0, 1 and 3, strobes, DRAM and NAND controls.
    st_next.dout = smc_data_out;
    // Upper data lanes are only driven on a 32-bit bus.
    st_next.doe  = {smc_data_oe[31:16] & {16{smc_wide_bus}},
                    smc_data_oe[15:0]};
    st_next.fixed = {
      st_reg.nand_on ? nand_write_req : 1'b1,   // 53
      st_reg.nand_on ? nand_read_req  : 1'b1,   // 52
      dram_addr_bit10,                          // 51
      dram_write_enable,                        // 50
      dram_cas_n,                               // 49
      dram_ras_n,                               // 48
      dram_clock_enable,                        // 47
      dram_clock,                               // 46
      smc_write_strobe_n[3],                    // 45
      smc_write_strobe_n[1],                    // 44
      smc_write_strobe_n[0],                    // 43
      smc_read_strobe_n,                        // 42
      smc_sel_n[3],                             // 41
      st_reg.ctrl[ebpc_pkg::SEL1_BIT] ? dram_sel_n
                                      : smc_sel_n[1], // 40
      smc_sel_n[0],                             // 39
      smc_addr[ebpc_pkg::FIX_ADDR_W-1:0],       // 38..16
      smc_data_out[ebpc_pkg::LOW_DATA_W-1:0]    // 15..0
    };

    st_next.porte = {
      smc_sel_n[2],                             // 25
      1'b1,                                     // 24 wait is an input
      st_reg.card_on ? card_rnw_req : 1'b1,     // 23
      smc_sel_n[5],                             // 22
      smc_sel_n[4],                             // 21
      st_reg.card_on ? card_enable2_req : 1'b1, // 20
      st_reg.card_on ? card_enable1_req : 1'b1, // 19
      smc_addr[ebpc_pkg::ADDR_W-1:ebpc_pkg::FIX_ADDR_W], // 18..16
      smc_data_out[31:16]                       // 15..0
    };

    // Low data pull-ups follow the control bit; port E follows its owner.
    st_next.pull_lo = {16{~st_reg.ctrl[ebpc_pkg::PULLUP_BIT]}};
    st_next.pull_e  = porte_pullup_cfg;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_reg          <= '0;
      st_reg.ctrl     <= ebpc_pkg::CTRL_RESET;
      st_reg.pull_lo  <= 16'hFFFF;
      st_reg.fixed    <= {54{1'b1}};
      st_reg.porte    <= {26{1'b1}};
      st_reg.dram_sel <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  assign prdata             = st_reg.rdata;
  assign pready             = st_reg.ready;
  assign pslverr            = 1'b0;
  assign data_out           = st_reg.dout;
  assign data_oe            = st_reg.doe;
  assign fixed_pin_out      = st_reg.fixed;
  assign porte_out          = st_reg.porte;
  assign low_data_pullup_en = st_reg.pull_lo;
  assign porte_pullup_en    = st_reg.pull_e;
  assign bus_data_in        = data_sync;
  assign bus_wait_n         = wait_sync[0];
  assign dram_sel_n_out     = st_reg.dram_sel;
  assign nand_active        = st_reg.nand_on;
  assign card_active        = st_reg.card_on;

  property p_pullup_follow;
    @(posedge pclk) disable iff (!presetn)
    ##1 low_data_pullup_en == {16{~$past(st_reg.ctrl[8])}};
  endproperty
  a_pullup_follow: assert property (p_pullup_follow)
    else $error("low data pull-ups disagree with control bit");

  property p_sel1_static;
    @(posedge pclk) disable iff (!presetn)
    (presetn && !st_reg.ctrl[1]) |=> fixed_pin_out[40] == $past(smc_sel_n[1]);
  endproperty
  a_sel1_static: assert property (p_sel1_static)
    else $error("select 1 not routed to static controller");

  property p_sel1_dram;
    @(posedge pclk) disable iff (!presetn)
    st_reg.ctrl[1] |=> fixed_pin_out[40] == $past(dram_sel_n);
  endproperty
  a_sel1_dram: assert property (p_sel1_dram)
    else $error("select 1 not routed to dram controller");

  property p_nand;
    @(posedge pclk) disable iff (!presetn)
    ##1 nand_active == $past(st_reg.ctrl[3]);
  endproperty
  a_nand: assert property (p_nand)
    else $error("nand glue does not follow select 3 bit");

  property p_card;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.ctrl[4] || st_reg.ctrl[5]) |=> card_active;
  endproperty
  a_card: assert property (p_card)
    else $error("card glue not active");

  property p_card_off;
    @(posedge pclk) disable iff (!presetn)
    (!st_reg.ctrl[4] && !st_reg.ctrl[5]) |=> !card_active;
  endproperty
  a_card_off: assert property (p_card_off)
    else $error("card glue active without assignment bits");

  property p_sel02;
    @(posedge pclk) disable iff (!presetn)
    presetn |=> fixed_pin_out[39] == $past(smc_sel_n[0])
        && porte_out[25] == $past(smc_sel_n[2]);
  endproperty
  a_sel02: assert property (p_sel02)
    else $error("select 0 or 2 not from static controller");

  property p_readback;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && pwrite && pready && hit)
      |=> st_reg.ctrl == ($past(pwdata) & ebpc_pkg::CTRL_MASK);
  endproperty
  a_readback: assert property (p_readback)
    else $error("readback mismatch");

  property p_porte_pull;
    @(posedge pclk) disable iff (!presetn)
    ##1 porte_pullup_en == $past(porte_pullup_cfg);
  endproperty
  a_porte_pull: assert property (p_porte_pull)
    else $error("port E pull-ups not from port controller");

  property p_read_data;
    @(posedge pclk) disable iff (!presetn)
    (acc && hit && !pwrite) |=> prdata == $past(st_reg.ctrl);
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data differs from control register");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn)
    (acc && !hit) |=> prdata == 32'h00000000
                      && st_reg.ctrl == $past(st_reg.ctrl);
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access reached the control register");

  property p_wait_state;
    @(posedge pclk) disable iff (!presetn)
    acc |=> pready ##1 !pready;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("ready is not a one cycle answer");

  property p_dram_sel_out;
    @(posedge pclk) disable iff (!presetn)
    presetn |=> dram_sel_n_out
                == ($past(st_reg.ctrl[1]) ? $past(dram_sel_n) : 1'b1);
  endproperty
  a_dram_sel_out: assert property (p_dram_sel_out)
    else $error("dram select output ignores select 1 bit");

  property p_nand_idle;
    @(posedge pclk) disable iff (!presetn)
    (presetn && !nand_active) |=> fixed_pin_out[53:52] == 2'h3;
  endproperty
  a_nand_idle: assert property (p_nand_idle)
    else $error("nand enables driven while glue is off");

  property p_card_idle;
    @(posedge pclk) disable iff (!presetn)
    (presetn && !card_active)
      |=> porte_out[23] && porte_out[20:19] == 2'h3;
  endproperty
  a_card_idle: assert property (p_card_idle)
    else $error("card strobes driven while glue is off");

  property p_card_pass;
    @(posedge pclk) disable iff (!presetn)
    card_active |=> porte_out[23] == $past(card_rnw_req)
      && porte_out[20:19] == {$past(card_enable2_req),
                              $past(card_enable1_req)};
  endproperty
  a_card_pass: assert property (p_card_pass)
    else $error("card strobes not passed while glue is on");

  property p_fixed_map;
    @(posedge pclk) disable iff (!presetn)
    presetn |=> fixed_pin_out[38:0]
                == {$past(smc_addr[22:0]), $past(smc_data_out[15:0])};
  endproperty
  a_fixed_map: assert property (p_fixed_map)
    else $error("fixed data or address pins misrouted");

  property p_porte_map;
    @(posedge pclk) disable iff (!presetn)
    presetn |=> porte_out[15:0] == $past(smc_data_out[31:16])
      && porte_out[18:16] == $past(smc_addr[25:23])
      && porte_out[22:21] == $past(smc_sel_n[5:4]);
  endproperty
  a_porte_map: assert property (p_porte_map)
    else $error("port E data, address or selects misrouted");

  property p_upper_oe;
    @(posedge pclk) disable iff (!presetn)
    (presetn && !smc_wide_bus) |=> data_oe[31:16] == 16'h0000;
  endproperty
  a_upper_oe: assert property (p_upper_oe)
    else $error("upper data lanes driven on a 16-bit bus");

  property p_reserved;
    @(posedge pclk) disable iff (!presetn)
    (st_reg.ctrl & ~32'h0000013A) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved control bits set");
endmodule : ebpc_top

// *** verif/ebpc_mem_model.sv ***
// Purpose: External memory on the shared bus, as seen from the pins.
// Assumes: Read strobe is fixed pin 42 and is active low.
// Notes:   Lines nobody drives toggle, so stale data cannot look valid; low lines with pull-ups on read high.
`timescale 1ns/10ps
module ebpc_mem_model #(
  parameter logic [31:0] RD_WORD = 32'h00000000
) (
  input  wire logic        pclk,
  input  wire logic        slow,
  input  wire logic [31:0] data_out,
  input  wire logic [31:0] data_oe,
  input  wire logic [53:0] fixed_pin_out,
  input  wire logic [15:0] low_data_pullup_en,
  output logic      [31:0] data_in,
  output logic             wait_request_n
);
  logic [31:0] idle_pat = 32'h0F0F0F0F;

  always @(posedge pclk)
    idle_pat <= ~idle_pat;

  // Wait is asserted only inside a read, so it can never be left stuck.
  assign wait_request_n = !(slow && !fixed_pin_out[42]);

  always_comb
  begin
    for (int i = 0; i < 32; i++)
    begin
      if (data_oe[i])
        data_in[i] = data_out[i];
      else if (!fixed_pin_out[42])
        data_in[i] = RD_WORD[i];
      else if (i < 16 && low_data_pullup_en[i[3:0]])
        data_in[i] = 1'b1;
      else
        data_in[i] = idle_pat[i];
    end
  end
endmodule : ebpc_mem_model

// *** verif/testbench.sv ***
// Purpose: Self-checking bench for the pin configuration block.
// Assumes: Control register at offset zero, APB slave with one wait state.
// Notes:   Pin outputs are compared three cycles after a change.
`timescale 1ns/10ps
module testbench;
  localparam logic [31:0] MEM_WORD = 32'hA5C35A3C;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, slow;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, smc_data_out, smc_data_oe, data_in;
  logic [31:0] data_out, data_oe, bus_data_in, rd;
  logic [25:0] smc_addr, porte_pullup_cfg, porte_out, porte_pullup_en;
  logic [53:0] fixed_pin_out;
  logic [15:0] low_data_pullup_en;
  logic [5:0]  smc_sel_n;
  logic [3:0]  smc_write_strobe_n;
  logic        smc_read_strobe_n, smc_wide_bus, dram_sel_n, dram_clock;
  logic        dram_clock_enable, dram_ras_n, dram_cas_n, dram_write_enable;
  logic        dram_addr_bit10, nand_read_req, nand_write_req, card_rnw_req;
  logic        card_enable1_req, card_enable2_req, wait_request_n;
  logic        bus_wait_n, dram_sel_n_out, nand_active, card_active, err;
  int          n_errors = 0;
  int          n_checks = 0;

  always #20 pclk = ~pclk;

  ebpc_top u_ebpc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .smc_sel_n, .smc_data_out,
    .smc_data_oe, .smc_addr, .smc_read_strobe_n, .smc_write_strobe_n,
    .smc_wide_bus, .dram_sel_n, .dram_clock, .dram_clock_enable,
    .dram_ras_n, .dram_cas_n, .dram_write_enable, .dram_addr_bit10,
    .nand_read_req, .nand_write_req, .card_enable1_req, .card_enable2_req,
    .card_rnw_req, .porte_pullup_cfg, .data_in, .wait_request_n, .data_out,
    .data_oe, .fixed_pin_out, .porte_out, .low_data_pullup_en,
    .porte_pullup_en, .bus_data_in, .bus_wait_n, .dram_sel_n_out,
    .nand_active, .card_active);

  ebpc_mem_model #(.RD_WORD(MEM_WORD)) u_ebpc_mem_model (.pclk, .slow,
    .data_out, .data_oe, .fixed_pin_out, .low_data_pullup_en, .data_in,
    .wait_request_n);

  task wrap_up;
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge pclk);
  endtask : tick

  // Request is held until pready is seen high at a rising edge.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task t_reg;
    apb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h0);
    chk(low_data_pullup_en, 16'hFFFF);
    apb(1'b1, 8'h00, 32'hFFFFFFFF, rd);
    apb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h0000013A);
    apb(1'b1, 8'h04, 32'h0, rd);
    apb(1'b0, 8'h04, 32'h0, rd);
    chk(rd, 32'h0);
    chk(err, 1'b0);
    apb(1'b0, 8'h00, 32'h0, rd);
    chk(rd, 32'h0000013A);
  endtask : t_reg

  task t_pins(input logic [31:0] c);
    logic [53:0] ef;
    logic [25:0] ep;
    apb(1'b1, 8'h00, c, rd);
    tick(3);
    ef = {c[3] ? {nand_write_req, nand_read_req} : 2'b11, dram_addr_bit10,
          dram_write_enable, dram_cas_n, dram_ras_n, dram_clock_enable,
          dram_clock, smc_write_strobe_n[3], smc_write_strobe_n[1:0],
          smc_read_strobe_n, smc_sel_n[3], c[1] ? dram_sel_n : smc_sel_n[1],
          smc_sel_n[0], smc_addr[22:0], smc_data_out[15:0]};
    ep = {smc_sel_n[2], 1'b1, (c[4] | c[5]) ? card_rnw_req : 1'b1,
          smc_sel_n[5:4],
          (c[4] | c[5]) ? {card_enable2_req, card_enable1_req} : 2'b11,
          smc_addr[25:23], smc_data_out[31:16]};
    chk(fixed_pin_out, ef);
    chk(porte_out, ep);
    chk(low_data_pullup_en, {16{~c[8]}});
    chk(dram_sel_n_out, c[1] ? dram_sel_n : 1'b1);
    chk({nand_active, card_active}, {c[3], c[4] | c[5]});
  endtask : t_pins

  task t_share;
    porte_pullup_cfg <= 26'h15A5A5A;
    smc_wide_bus <= 1'b0;
    tick(3);
    chk(porte_pullup_en, 26'h15A5A5A);
    chk(data_oe, {16'h0, smc_data_oe[15:0]});
    smc_wide_bus <= 1'b1;
    tick(3);
    chk(data_oe, smc_data_oe);
    chk(data_out, smc_data_out);
  endtask : t_share

  task t_read;
    apb(1'b1, 8'h00, 32'h0, rd);
    smc_data_oe <= 32'h0;
    smc_read_strobe_n <= 1'b0;
    slow <= 1'b1;
    tick(5);
    chk(bus_data_in, MEM_WORD);
    chk(bus_wait_n, 1'b0);
    smc_read_strobe_n <= 1'b1;
    slow <= 1'b0;
    tick(5);
    chk(bus_data_in[15:0], 16'hFFFF);
    chk(bus_wait_n, 1'b1);
  endtask : t_read

  initial
  begin
    repeat (5000) @(posedge pclk);
    n_errors++;
    wrap_up();
  end

  initial
  begin
    {presetn, psel, penable, pwrite, slow} <= '0;
    paddr <= 8'h00;
    pwdata <= 32'h0;
    {smc_data_out, smc_data_oe} <= {32'h1234ABCD, 32'hFFFFFFFF};
    {smc_addr, porte_pullup_cfg} <= {26'h2C3A5F1, 26'h0};
    // Select 5 stays idle all run: its address region is off limits.
    smc_sel_n <= 6'h2A;
    {dram_sel_n, smc_write_strobe_n} <= {1'b0, 4'h5};
    {smc_read_strobe_n, smc_wide_bus} <= 2'h3;
    {dram_clock, dram_clock_enable, dram_ras_n} <= 3'h5;
    {dram_cas_n, dram_write_enable, dram_addr_bit10} <= 3'h1;
    {nand_read_req, nand_write_req, card_rnw_req} <= 3'h0;
    {card_enable1_req, card_enable2_req} <= 2'h0;
    tick(5);
    presetn <= 1'b1;
    tick(1);
    t_reg();
    t_pins(32'h0);
    t_pins(32'h2);
    t_pins(32'h8);
    t_pins(32'h10);
    t_pins(32'h20);
    t_pins(32'h13A);
    t_share();
    t_read();
    wrap_up();
  end
endmodule : testbench
